// ### rtl/fsdpc_top.sv
// switch control, forced sleep and discharge protection register bank
// assumes AXI4-Lite from the host and synchronous detector inputs
//
// Operation
// - writing force-sleep one enters sleep, drops FETs, balance and regulator
// - sleep entry clears switch enables and balance bits, keeps analog select
// - force-sleep bit returns to zero when the device wakes
// - sleep starts only on a zero-to-one change of force-sleep
// - load monitor bit turns the load-voltage monitor on or off
// - switch-control bits 5 to 2 are reserved and do nothing
// - charge switch bit drives the charge FET
// - charge overcurrent clears charge switch unless its auto-off is disabled
// - over-temperature clears both switches unless thermal shutdown is disabled
// - discharge switch bit drives the discharge FET
// - discharge overcurrent or short clears discharge switch unless disabled
// - discharge overcurrent auto-off disable bit blocks the automatic switch-off
// - discharge overcurrent always sets its flag, flag powers temperature sensor
// - bits 6:5 select overcurrent threshold 0.10V to 0.16V
// - short-circuit auto-off disable bit blocks the automatic switch-off
// - short-circuit always sets its flag, flag powers temperature sensor
// - bits 3:2 select short-circuit threshold 0.20V to 1.20V
// - bits 1:0 select overcurrent time-out 160ms to 1280ms
// - divider bit divides the overcurrent time-out by 64
// - overcurrent flag clears on status read once the condition is gone
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module fsdpc_top
    import fsdpc_pkg::*;
#(
    parameter int OC_BASE_CYCLES = OC_BASE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic oc_detect_i,
    input wire logic short_detect_i,
    input wire logic charge_oc_i,
    input wire logic ext_overtemp_i,
    input wire logic int_overtemp_i,
    input wire logic wake_i,
    output logic charge_fet_o,
    output logic discharge_fet_o,
    output logic [BAL_N-1:0] balance_o,
    output logic [AN_N-1:0] analog_out_select_o,
    output logic regulator_en_o,
    output logic load_voltage_monitor_o,
    output logic [1:0] oc_threshold_sel_o,
    output logic [1:0] short_threshold_sel_o,
    output logic temp_sensor_supply_out_o,
    output logic sleep_o
);
    fsdpc_pwr_t pwr_q;
    logic force_sleep_q, load_monitor_enable_q, charge_switch_enable_q, discharge_switch_enable_q;
    logic [BAL_N-1:0] balance_switch_bits_q;
    logic [AN_N-1:0] analog_out_select_q;
    logic [7:0] dischg_cfg_q;
    logic charge_oc_autooff_disable_q, discharge_delay_divider_q, thermal_shutdown_disable_q;
    logic discharge_overcurrent_flag_q, short_circuit_flag_q;
    logic [31:0] oc_cnt_q, oc_limit;
    logic oc_fired_q, oc_trip, short_q, short_trip;

    logic aw_hold_q, w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write, wr_lane0, rd_take, sleep_start, wake_now, overtemp;
    logic [ADDR_W-3:0] widx, ridx;
    logic [7:0] rd_byte;
    logic rd_hit;

    // write address and data are taken independently, then applied together
    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid_o;
    assign widx = awaddr_q[ADDR_W-1:2];
    assign ridx = s_axi_araddr_i[ADDR_W-1:2];
    assign wr_lane0 = do_write && wstrb_q[0];
    assign rd_take = s_axi_arvalid_i && s_axi_arready_o;
    assign wake_now = (pwr_q == FSDPC_ASLEEP) && wake_i;
    assign overtemp = ext_overtemp_i || int_overtemp_i;

    assign sleep_start = wr_lane0 && (widx == SWITCH_IDX[ADDR_W-3:0]) && wdata_q[SW_FORCE_SLEEP]
        && !force_sleep_q && (pwr_q == FSDPC_AWAKE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_awready_o <= 1'b1;
            aw_hold_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            aw_hold_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_wready_o <= 1'b1;
            w_hold_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_wready_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= (widx == BALANCE_IDX[ADDR_W-3:0] || widx == ANALOG_IDX[ADDR_W-3:0]
                || widx == SWITCH_IDX[ADDR_W-3:0] || widx == DISCHG_IDX[ADDR_W-3:0]
                || widx == TSCALE_IDX[ADDR_W-3:0] || widx == STATUS_IDX[ADDR_W-3:0])
                ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        unique case (ridx)
            STATUS_IDX[ADDR_W-3:0]: rd_byte = {5'h00, short_circuit_flag_q, discharge_overcurrent_flag_q,
                                              thermal_shutdown_disable_q};
            BALANCE_IDX[ADDR_W-3:0]: rd_byte = {1'b0, balance_switch_bits_q, 1'b0};
            ANALOG_IDX[ADDR_W-3:0]: rd_byte = {4'h0, analog_out_select_q};
            SWITCH_IDX[ADDR_W-3:0]: rd_byte = {force_sleep_q, load_monitor_enable_q, 4'h0,
                                              charge_switch_enable_q, discharge_switch_enable_q};
            DISCHG_IDX[ADDR_W-3:0]: rd_byte = dischg_cfg_q;
            TSCALE_IDX[ADDR_W-3:0]: rd_byte = {charge_oc_autooff_disable_q, 4'h0,
                                              discharge_delay_divider_q, 2'b00};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {24'h00_0000, rd_byte};
            s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // power state; regulator drops while asleep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_q <= FSDPC_AWAKE;
        end else if (sleep_start) begin
            pwr_q <= FSDPC_ASLEEP;
        end else if (wake_now) begin
            pwr_q <= FSDPC_AWAKE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_sleep_q <= 1'b0;
        end else if (wake_now) begin
            force_sleep_q <= 1'b0;
        end else if (wr_lane0 && widx == SWITCH_IDX[ADDR_W-3:0]) begin
            force_sleep_q <= wdata_q[SW_FORCE_SLEEP];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_monitor_enable_q <= SWITCH_RST[SW_LOAD_MON];
        end else if (wr_lane0 && widx == SWITCH_IDX[ADDR_W-3:0]) begin
            load_monitor_enable_q <= wdata_q[SW_LOAD_MON];
        end
    end

    // protective clears override a host write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            charge_switch_enable_q <= SWITCH_RST[SW_CHARGE];
        end else if (sleep_start) begin
            charge_switch_enable_q <= 1'b0;
        end else if (charge_oc_i && !charge_oc_autooff_disable_q) begin
            charge_switch_enable_q <= 1'b0;
        end else if (overtemp && !thermal_shutdown_disable_q) begin
            charge_switch_enable_q <= 1'b0;
        end else if (wr_lane0 && widx == SWITCH_IDX[ADDR_W-3:0]) begin
            charge_switch_enable_q <= wdata_q[SW_CHARGE];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            discharge_switch_enable_q <= SWITCH_RST[SW_DISCHARGE];
        end else if (sleep_start) begin
            discharge_switch_enable_q <= 1'b0;
        end else if ((oc_trip && !dischg_cfg_q[DP_OC_AUTOOFF_DIS])
                     || (short_trip && !dischg_cfg_q[DP_SC_AUTOOFF_DIS])) begin
            discharge_switch_enable_q <= 1'b0;
        end else if (overtemp && !thermal_shutdown_disable_q) begin
            discharge_switch_enable_q <= 1'b0;
        end else if (wr_lane0 && widx == SWITCH_IDX[ADDR_W-3:0]) begin
            discharge_switch_enable_q <= wdata_q[SW_DISCHARGE];
        end
    end

    // balance cleared by sleep, analog select untouched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            balance_switch_bits_q <= '0;
        end else if (sleep_start) begin
            balance_switch_bits_q <= '0;
        end else if (wr_lane0 && widx == BALANCE_IDX[ADDR_W-3:0]) begin
            balance_switch_bits_q <= wdata_q[BAL_LO +: BAL_N];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_out_select_q <= '0;
        end else if (wr_lane0 && widx == ANALOG_IDX[ADDR_W-3:0]) begin
            analog_out_select_q <= wdata_q[AN_N-1:0];
        end
    end

    // overcurrent and short-circuit auto-off disables held with thresholds and time-out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dischg_cfg_q <= DISCHG_RST;
        end else if (wr_lane0 && widx == DISCHG_IDX[ADDR_W-3:0]) begin
            dischg_cfg_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            charge_oc_autooff_disable_q <= TSCALE_RST[TS_CHG_AUTOOFF_DIS];
            discharge_delay_divider_q <= TSCALE_RST[TS_DISCH_DIVIDER];
        end else if (wr_lane0 && widx == TSCALE_IDX[ADDR_W-3:0]) begin
            charge_oc_autooff_disable_q <= wdata_q[TS_CHG_AUTOOFF_DIS];
            discharge_delay_divider_q <= wdata_q[TS_DISCH_DIVIDER];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thermal_shutdown_disable_q <= 1'b0;
        end else if (wr_lane0 && widx == STATUS_IDX[ADDR_W-3:0]) begin
            thermal_shutdown_disable_q <= wdata_q[ST_THERMAL_DIS];
        end
    end

    // time-out is base doubled per code, optionally over 64
    assign oc_limit = discharge_delay_divider_q
        ? ((32'(OC_BASE_CYCLES) << dischg_cfg_q[DP_OC_TIME_LO +: 2]) >> DIV_SHIFT)
        : (32'(OC_BASE_CYCLES) << dischg_cfg_q[DP_OC_TIME_LO +: 2]);
    assign oc_trip = oc_detect_i && !oc_fired_q && (oc_cnt_q >= oc_limit - 32'd1);

    // counter restarts whenever the condition drops
    always_ff @(posedge clk_i) begin
        if (rst_i || !oc_detect_i) begin
            oc_cnt_q <= '0;
            oc_fired_q <= 1'b0;
        end else if (oc_trip) begin
            oc_fired_q <= 1'b1;
        end else if (!oc_fired_q) begin
            oc_cnt_q <= oc_cnt_q + 32'd1;
        end
    end

    // short detector is already delay-qualified; act on its leading edge
    assign short_trip = short_detect_i && !short_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            short_q <= 1'b0;
        end else begin
            short_q <= short_detect_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            discharge_overcurrent_flag_q <= 1'b0;
        end else if (oc_trip) begin
            discharge_overcurrent_flag_q <= 1'b1;
        end else if (rd_take && ridx == STATUS_IDX[ADDR_W-3:0] && !oc_detect_i) begin
            discharge_overcurrent_flag_q <= 1'b0;
        end
    end

    // short flag, cleared the same way
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            short_circuit_flag_q <= 1'b0;
        end else if (short_trip) begin
            short_circuit_flag_q <= 1'b1;
        end else if (rd_take && ridx == STATUS_IDX[ADDR_W-3:0] && !short_detect_i) begin
            short_circuit_flag_q <= 1'b0;
        end
    end

    // outputs registered from the state above
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            charge_fet_o <= 1'b0;
            discharge_fet_o <= 1'b0;
            balance_o <= '0;
            analog_out_select_o <= '0;
            regulator_en_o <= 1'b1;
            load_voltage_monitor_o <= 1'b0;
            oc_threshold_sel_o <= 2'b00;
            short_threshold_sel_o <= 2'b00;
            temp_sensor_supply_out_o <= 1'b0;
            sleep_o <= 1'b0;
        end else begin
            charge_fet_o <= charge_switch_enable_q && pwr_q == FSDPC_AWAKE;
            discharge_fet_o <= discharge_switch_enable_q && pwr_q == FSDPC_AWAKE;
            balance_o <= (pwr_q == FSDPC_AWAKE) ? balance_switch_bits_q : '0;
            analog_out_select_o <= analog_out_select_q;
            regulator_en_o <= pwr_q == FSDPC_AWAKE;
            load_voltage_monitor_o <= load_monitor_enable_q;
            oc_threshold_sel_o <= dischg_cfg_q[DP_OC_THR_LO +: 2];
            short_threshold_sel_o <= dischg_cfg_q[DP_SC_THR_LO +: 2];
            temp_sensor_supply_out_o <= discharge_overcurrent_flag_q || short_circuit_flag_q;
            sleep_o <= pwr_q == FSDPC_ASLEEP;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_sleep_req;
        sleep_start;
    endsequence
    sequence s_pins_off;
        !charge_fet_o && !discharge_fet_o && balance_o == '0 && !regulator_en_o;
    endsequence

    a_sleep_pins_off: assert property (s_sleep_req |-> ##2 s_pins_off)
        else $error("sleep entry left a FET, balance or regulator on");
    a_sleep_clears_bits: assert property (sleep_start |=> !charge_switch_enable_q && !discharge_switch_enable_q
        && balance_switch_bits_q == '0 && analog_out_select_q == $past(analog_out_select_q))
        else $error("sleep entry did not clear enables or changed analog select");
    a_wake_clears_force: assert property (wake_now |=> !force_sleep_q && pwr_q == FSDPC_AWAKE)
        else $error("force-sleep bit not cleared on wake");
    a_no_edge_no_sleep: assert property (pwr_q == FSDPC_AWAKE && !sleep_start |=> pwr_q == FSDPC_AWAKE)
        else $error("sleep entered without a rising force-sleep write");
    a_charge_oc_off: assert property (charge_oc_i && !charge_oc_autooff_disable_q |-> ##2 !charge_fet_o)
        else $error("charge overcurrent did not drop the charge FET");
    a_thermal_off: assert property (overtemp && !thermal_shutdown_disable_q
        |=> !charge_switch_enable_q && !discharge_switch_enable_q)
        else $error("over-temperature did not clear the switches");
    a_doc_discharge_switch_enable_off: assert property (oc_trip && !dischg_cfg_q[DP_OC_AUTOOFF_DIS] |-> ##2 !discharge_fet_o)
        else $error("discharge overcurrent did not drop the discharge FET");
    a_doc_flag_temp: assert property (oc_trip |=> discharge_overcurrent_flag_q ##1 temp_sensor_supply_out_o)
        else $error("overcurrent flag or sensor supply missing");
    a_scd_flag_temp: assert property (short_trip |=> short_circuit_flag_q ##1 temp_sensor_supply_out_o)
        else $error("short flag or sensor supply missing");
    a_oc_restart: assert property ($fell(oc_detect_i) |-> !oc_trip ##1 oc_cnt_q == '0)
        else $error("time-out counter not restarted");
    a_flag_read_clear: assert property (rd_take && ridx == STATUS_IDX[ADDR_W-3:0] && !oc_detect_i
        |=> !discharge_overcurrent_flag_q)
        else $error("overcurrent flag survived a read after the condition ended");
endmodule : fsdpc_top

// ### rtl/fsdpc_pkg.sv
// constants for the switch / sleep / discharge protection register bank
// assumes a 100 MHz core clock and AXI4-Lite register access
package fsdpc_pkg;
    // printed register indexes; the byte address is four times the index
    localparam logic [7:0] STATUS_IDX = 8'h01;
    localparam logic [7:0] BALANCE_IDX = 8'h02;
    localparam logic [7:0] ANALOG_IDX = 8'h03;
    localparam logic [7:0] SWITCH_IDX = 8'h04;
    localparam logic [7:0] DISCHG_IDX = 8'h05;
    localparam logic [7:0] TSCALE_IDX = 8'h06;
    localparam int ADDR_W = 8;

    // switch_sleep_control fields
    localparam int SW_FORCE_SLEEP = 7;
    localparam int SW_LOAD_MON = 6;
    localparam int SW_CHARGE = 1;
    localparam int SW_DISCHARGE = 0;
    // discharge_protection_config fields
    localparam int DP_OC_AUTOOFF_DIS = 7;
    localparam int DP_OC_THR_LO = 5;
    localparam int DP_SC_AUTOOFF_DIS = 4;
    localparam int DP_SC_THR_LO = 2;
    localparam int DP_OC_TIME_LO = 0;
    // time-scale register fields
    localparam int TS_CHG_AUTOOFF_DIS = 7;
    localparam int TS_DISCH_DIVIDER = 2;
    // status fields
    localparam int ST_DOC = 1;
    localparam int ST_SCD = 2;
    localparam int ST_THERMAL_DIS = 0;
    // balance bits sit in 6:1, analog select in 3:0
    localparam int BAL_LO = 1;
    localparam int BAL_N = 6;
    localparam int AN_N = 4;

    localparam logic [7:0] DISCHG_RST = 8'h00;
    localparam logic [7:0] SWITCH_RST = 8'h00;
    localparam logic [7:0] TSCALE_RST = 8'h00;

    // discharge overcurrent time-out base (code 00, divider clear)
    localparam int CLK_MHZ = 100;
    localparam int OC_BASE_MS = 160;
    localparam int OC_BASE_CYC = OC_BASE_MS * 1000 * CLK_MHZ;
    localparam int DIV_SHIFT = 6;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic {FSDPC_AWAKE, FSDPC_ASLEEP} fsdpc_pwr_t;
endpackage : fsdpc_pkg

// ### testbench/fsdpc_host_model.sv
// register master standing in for the pack microcontroller
// assumes one clock shared with the bank; ports named as the bank's
`timescale 1ns/100ps
module fsdpc_host_model
    import fsdpc_pkg::*;
(
    input wire logic clk_i,
    output logic [ADDR_W-1:0] s_axi_awaddr_i,
    output logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    output logic [31:0] s_axi_wdata_i,
    output logic [3:0] s_axi_wstrb_i,
    output logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    output logic s_axi_bready_i,
    output logic [ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    output logic s_axi_rready_i
);
    initial begin
        {s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
        {s_axi_wvalid_i, s_axi_araddr_i, s_axi_arvalid_i} = '0;
        // response readies stay high so back-to-back calls never drop and raise them in one step
        s_axi_bready_i = 1'b1;
        s_axi_rready_i = 1'b1;
    end
    // called just after a rising edge; bounded so a dead slave cannot hang
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
        int n = 0;
        s_axi_awaddr_i <= ADDR_W'(idx << 2);
        s_axi_awvalid_i <= 1'b1;
        s_axi_wdata_i <= 32'(d);
        s_axi_wstrb_i <= 4'hf;
        s_axi_wvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o && n < 64);
        r = s_axi_bresp_o;
        if (n >= 64) tb_top.hang();
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        s_axi_araddr_i <= ADDR_W'(idx << 2);
        s_axi_arvalid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o && n < 64);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        if (n >= 64) tb_top.hang();
    endtask : rd
endmodule : fsdpc_host_model

// ### testbench/tb_top.sv
// self-checking bench for the switch, sleep and discharge protection bank
// assumes fsdpc_host_model as register master on the same clock
`timescale 1ns/100ps
module tb_top
    import fsdpc_pkg::*;
;
    // short base count keeps time-outs to a few hundred cycles
    localparam int OCB = 128;
    int miscompares = 0;
    int checks_done = 0;
    logic [31:0] d;
    logic [1:0] r;
    logic clk_i, rst_i, oc_detect_i, short_detect_i, charge_oc_i, ext_overtemp_i, int_overtemp_i, wake_i;
    logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, oc_threshold_sel_o, short_threshold_sel_o;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
    logic charge_fet_o, discharge_fet_o, regulator_en_o, load_voltage_monitor_o, temp_sensor_supply_out_o, sleep_o;
    logic [BAL_N-1:0] balance_o;
    logic [AN_N-1:0] analog_out_select_o;
    fsdpc_top #(.OC_BASE_CYCLES(OCB)) DUT (.*);
    fsdpc_host_model h (.*);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic hang;
        miscompares++;
        $display("[ERR] %0t bus wait timed out", $time);
        finish_test();
    endtask : hang
    task automatic w(input logic [7:0] idx, input logic [7:0] v);
        h.wr(idx, v, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask : w
    task automatic rc(input logic [7:0] idx, input logic [7:0] e);
        h.rd(idx, d, r);
        chk(d, 32'(e));
        chk(32'(r), 32'(RESP_OKAY));
    endtask : rc
    // one-cycle event on charge oc, ext temp, int temp, wake
    task automatic ev(input logic [3:0] m);
        {charge_oc_i, ext_overtemp_i, int_overtemp_i, wake_i} <= m;
        cyc(1);
        {charge_oc_i, ext_overtemp_i, int_overtemp_i, wake_i} <= 4'h0;
        cyc(3);
    endtask : ev
    // holds overcurrent until the discharge FET drops or a margin runs out
    task automatic oc_run(input int lim, input logic en);
        int n = 0;
        oc_detect_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (discharge_fet_o === 1'b1 && n < lim + 20);
        oc_detect_i <= 1'b0;
        chk(32'(n >= lim && n <= lim + 4), 32'(en));
        chk(32'(temp_sensor_supply_out_o), 32'h0000_0001);
        cyc(1);
        rc(STATUS_IDX, 8'h02);
        rc(STATUS_IDX, 8'h00);
    endtask : oc_run
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        rst_i = 1'b1;
        {oc_detect_i, short_detect_i, charge_oc_i, ext_overtemp_i, int_overtemp_i, wake_i} = '0;
        cyc(20);
        rst_i <= 1'b0;
        cyc(1);
        chk(32'({regulator_en_o, sleep_o, discharge_fet_o}), 32'h0000_0004);
        rc(SWITCH_IDX, SWITCH_RST);
        rc(DISCHG_IDX, DISCHG_RST);
        w(SWITCH_IDX, 8'h7f);
        rc(SWITCH_IDX, 8'h43);
        cyc(2);
        chk(32'({load_voltage_monitor_o, charge_fet_o, discharge_fet_o}), 32'h0000_0007);
        w(DISCHG_IDX, 8'h2c);
        cyc(2);
        chk(32'({oc_threshold_sel_o, short_threshold_sel_o}), 32'h0000_0007);
        // an interrupted episode must not shorten the next one
        oc_detect_i <= 1'b1;
        cyc(OCB - 8);
        oc_detect_i <= 1'b0;
        cyc(2);
        oc_run(OCB, 1'b1);
        w(TSCALE_IDX, 8'h04);
        w(DISCHG_IDX, 8'h01);
        w(SWITCH_IDX, 8'h01);
        oc_run((OCB << 1) >> DIV_SHIFT, 1'b1);
        w(DISCHG_IDX, 8'h81);
        // previous trip cleared the discharge switch; re-arm so the disable is really exercised
        w(SWITCH_IDX, 8'h01);
        oc_run((OCB << 1) >> DIV_SHIFT, 1'b0);
        for (int i = 0; i < 2; i++) begin
            w(DISCHG_IDX, i ? 8'h00 : 8'h10);
            w(SWITCH_IDX, 8'h03);
            short_detect_i <= 1'b1;
            cyc(4);
            short_detect_i <= 1'b0;
            chk(32'(discharge_fet_o), 32'(i == 0));
            cyc(1);
            rc(STATUS_IDX, 8'h04);
            rc(STATUS_IDX, 8'h00);
        end
        // the last short cleared the discharge switch; restore both before the charge event
        w(SWITCH_IDX, 8'h03);
        ev(4'h8);
        chk(32'({charge_fet_o, discharge_fet_o}), 32'h0000_0001);
        w(TSCALE_IDX, 8'h80);
        w(SWITCH_IDX, 8'h03);
        ev(4'h8);
        chk(32'({charge_fet_o, discharge_fet_o}), 32'h0000_0003);
        ev(4'h4);
        chk(32'({charge_fet_o, discharge_fet_o}), 32'h0000_0000);
        w(STATUS_IDX, 8'h01);
        w(SWITCH_IDX, 8'h03);
        ev(4'h2);
        chk(32'({charge_fet_o, discharge_fet_o}), 32'h0000_0003);
        w(ANALOG_IDX, 8'h05);
        w(BALANCE_IDX, 8'h7e);
        cyc(2);
        chk(32'(balance_o), 32'h0000_003f);
        w(SWITCH_IDX, 8'h00);
        w(SWITCH_IDX, 8'h83);
        cyc(2);
        chk(32'({sleep_o, charge_fet_o, discharge_fet_o, regulator_en_o, balance_o, analog_out_select_o}),
            32'h0000_2005);
        rc(BALANCE_IDX, 8'h00);
        ev(4'h1);
        rc(SWITCH_IDX, 8'h00);
        chk(32'(sleep_o), 32'h0000_0000);
        h.wr(8'h3f, 8'h11, r);
        chk(32'(r), 32'(RESP_SLVERR));
        h.rd(8'h3f, d, r);
        chk({d[29:0], r}, 32'(RESP_SLVERR));
        finish_test();
    end
endmodule : tb_top
